// file: hw/bds_pkg.sv
/*
 bds_pkg: build size, pipeline positions and reset values for the
 two-beat double-data-rate static memory port.
 Assumes: one build per compile, chosen by WIDE_BUILD.
*/
package bds_pkg;

	// -------------------------------------------------------------
	// build
	// -------------------------------------------------------------
	localparam int WIDE_BUILD = 0;
	localparam int DATA_W     = (WIDE_BUILD != 0) ? 36 : 18;
	localparam int ADDR_W     = (WIDE_BUILD != 0) ? 18 : 19;
	localparam int BYTE_W     = 9;
	localparam int NBYTE      = DATA_W / BYTE_W;
	localparam int DEPTH      = 1 << ADDR_W;
	localparam int BEATS      = 2;

	// -------------------------------------------------------------
	// synchroniser and read pipeline
	// -------------------------------------------------------------
	localparam int SYNC_N       = 3;
	localparam int PIPE_N       = 7;
	localparam int HALF_LAT_DLL = 5;
	localparam int HALF_LAT_BYP = 2;
	localparam int BYP_MAX_MHZ  = 167;

	// -------------------------------------------------------------
	// reset values
	// -------------------------------------------------------------
	localparam logic ECHO_RST  = 1'h0;
	localparam logic DLL_RST   = 1'h1;
	localparam logic [2:0] HCNT_MAX = 3'h7;

endpackage

// file: hw/bds_port.sv
/*
 bds_port: device side of a separate-I/O static memory with two-beat
 double-data-rate bursts, echo clocks and a read-valid flag.
 Assumes: the host drives the input clock pair slowly against i_clock
 (rise edges of the pair at least four i_clock cycles apart) and holds each
 input steady for two i_clock cycles either side of its clock edge.
*/
// Summary of operation
// - build is 512K words by 36 or 1M words by 18, fixed
// - read and write ports run independently and concurrently
// - every read and write moves exactly two beats
// - primary clock rise starts each operation, rest is timed by the input clock half edges
// - read address on primary rise, write address on inverted rise
// - primary rise registers read address, both selects, first write beat
// - inverted rise registers write address, second mask, second write beat
// - masks travel per beat, only enabled bytes are written
// - write buffer holds data until the write address arrives
// - first read beat leaves 2.5 cycles after the read command with dll on, one cycle in bypass
// - second read beat follows on third primary rise after command with dll on, 1.5 cycles after it in bypass
// - read outputs are timed from the input clock pair only
// - echo clock pair toggles in step with the read beats
// - read-valid flag marks periods with valid burst data
// - all inputs and the read data are registered
// - read-valid flag changes with the echo clock edges
// - echo clocks run continuously, also while data is idle
// - dll enable low selects one-cycle read latency bypass mode
// - address is ignored when no operation is selected
`timescale 1ns/1ps

module bds_port
	import bds_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire logic              i_in_clock,
	input  wire logic              i_in_clock_inverted,
	input  wire logic [ADDR_W-1:0] i_addr_in,
	input  wire logic              i_read_sel_n,
	input  wire logic              i_write_sel_n,
	input  wire logic [DATA_W-1:0] i_write_data_in,
	input  wire logic [NBYTE-1:0]  i_byte_write_mask_n,
	input  wire logic              i_dll_enable,
	output logic      [DATA_W-1:0] o_read_data_out,
	output logic                   o_read_data_oe,
	output logic                   o_read_valid_flag,
	output logic                   o_echo_clock,
	output logic                   o_echo_clock_inverted
);

	// -------------------------------------------------------------
	// functions
	// -------------------------------------------------------------
	function automatic logic [DATA_W-1:0] merge_bytes(
		input logic [DATA_W-1:0] old_word,
		input logic [DATA_W-1:0] new_word,
		input logic [NBYTE-1:0]  mask_n
	);
		logic [DATA_W-1:0] res;
		res = old_word;
		for (int b = 0; b < NBYTE; b++) begin
			if (!mask_n[b]) begin
				res[b*BYTE_W +: BYTE_W] = new_word[b*BYTE_W +: BYTE_W];
			end
		end
		return res;
	endfunction

	function automatic logic [2:0] first_pos(input logic dll_on);
		int lat;
		lat = dll_on ? HALF_LAT_DLL : HALF_LAT_BYP;
		return 3'((PIPE_N - 1) - lat);
	endfunction

	// -------------------------------------------------------------
	// input synchronisers
	// -------------------------------------------------------------
	logic [SYNC_N-1:0] k_s;
	logic [SYNC_N-1:0] kn_s;
	logic [SYNC_N-1:0] rsel_s;
	logic [SYNC_N-1:0] wsel_s;
	logic [SYNC_N-1:0] dll_s;
	logic [ADDR_W-1:0] a_s [0:SYNC_N-1];
	logic [DATA_W-1:0] d_s [0:SYNC_N-1];
	logic [NBYTE-1:0]  m_s [0:SYNC_N-1];

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			k_s    <= '0;
			kn_s   <= '0;
			rsel_s <= '1;
			wsel_s <= '1;
			dll_s  <= '1;
			for (int i = 0; i < SYNC_N; i++) begin
				a_s[i] <= '0;
				d_s[i] <= '0;
				m_s[i] <= '1;
			end
		end else begin
			k_s    <= {k_s[SYNC_N-2:0], i_in_clock};
			kn_s   <= {kn_s[SYNC_N-2:0], i_in_clock_inverted};
			rsel_s <= {rsel_s[SYNC_N-2:0], i_read_sel_n};
			wsel_s <= {wsel_s[SYNC_N-2:0], i_write_sel_n};
			dll_s  <= {dll_s[SYNC_N-2:0], i_dll_enable};
			a_s[0] <= i_addr_in;
			d_s[0] <= i_write_data_in;
			m_s[0] <= i_byte_write_mask_n;
			for (int i = 1; i < SYNC_N; i++) begin
				a_s[i] <= a_s[i-1];
				d_s[i] <= d_s[i-1];
				m_s[i] <= m_s[i-1];
			end
		end
	end

	// -------------------------------------------------------------
	// edge finding on agreed levels
	// -------------------------------------------------------------
	logic k_lvl;
	logic kn_lvl;
	logic dll_on;
	logic k_agree;
	logic kn_agree;
	logic k_rise;
	logic kn_rise;
	logic half_edge;

	assign k_agree   = (k_s[1] == k_s[2]);
	assign kn_agree  = (kn_s[1] == kn_s[2]);
	assign k_rise    = k_agree && k_s[2] && !k_lvl;
	assign kn_rise   = kn_agree && kn_s[2] && !kn_lvl;
	assign half_edge = k_rise || kn_rise;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			k_lvl  <= 1'h0;
			kn_lvl <= 1'h0;
			dll_on <= DLL_RST;
		end else begin
			if (k_agree) begin
				k_lvl <= k_s[2];
			end
			if (kn_agree) begin
				kn_lvl <= kn_s[2];
			end
			if (dll_s[1] == dll_s[2]) begin
				dll_on <= dll_s[2];
			end
		end
	end

	// -------------------------------------------------------------
	// commands
	// -------------------------------------------------------------
	logic rd_go;
	logic wr_go;

	assign rd_go = k_rise && !rsel_s[2];
	assign wr_go = k_rise && !wsel_s[2];

	// -------------------------------------------------------------
	// storage
	// -------------------------------------------------------------
	logic [DATA_W-1:0] mem [0:DEPTH-1][0:BEATS-1];

	// -------------------------------------------------------------
	// write port with buffer
	// -------------------------------------------------------------
	logic              wr_pend;
	logic [DATA_W-1:0] wr_beat0;
	logic [NBYTE-1:0]  wr_mask0;
	logic [ADDR_W-1:0] wr_addr;
	logic [ADDR_W-1:0] rd_addr;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			wr_pend  <= 1'h0;
			wr_beat0 <= '0;
			wr_mask0 <= '1;
		end else if (wr_go) begin
			wr_pend  <= 1'h1;
			wr_beat0 <= d_s[2];
			wr_mask0 <= m_s[2];
		end else if (kn_rise) begin
			wr_pend  <= 1'h0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			wr_addr <= '0;
			rd_addr <= '0;
		end else begin
			if (kn_rise && wr_pend) begin
				wr_addr <= a_s[2];
			end
			if (rd_go) begin
				rd_addr <= a_s[2];
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (kn_rise && wr_pend) begin
			mem[a_s[2]][0] <= merge_bytes(mem[a_s[2]][0], wr_beat0, wr_mask0);
			mem[a_s[2]][1] <= merge_bytes(mem[a_s[2]][1], d_s[2], m_s[2]);
		end
	end

	// -------------------------------------------------------------
	// read pipeline, one step per input clock half edge
	// -------------------------------------------------------------
	logic              pv [0:PIPE_N-1];
	logic              ps [0:PIPE_N-1];
	logic [DATA_W-1:0] pd [0:PIPE_N-1];
	logic [2:0]        p0;
	logic [2:0]        p1;

	assign p1 = first_pos(dll_on);
	assign p0 = p1 - 3'h1;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			for (int i = 0; i < PIPE_N; i++) begin
				pv[i] <= 1'h0;
				ps[i] <= 1'h0;
				pd[i] <= '0;
			end
		end else if (half_edge) begin
			pv[0] <= 1'h0;
			ps[0] <= 1'h0;
			pd[0] <= '0;
			for (int i = 1; i < PIPE_N; i++) begin
				pv[i] <= pv[i-1];
				ps[i] <= ps[i-1];
				pd[i] <= pd[i-1];
			end
			if (rd_go) begin
				pv[p1] <= 1'h1;
				ps[p1] <= 1'h0;
				pd[p1] <= mem[a_s[2]][0];
				pv[p0] <= 1'h1;
				ps[p0] <= 1'h1;
				pd[p0] <= mem[a_s[2]][1];
			end
		end
	end

	assign o_read_data_out   = pd[PIPE_N-1];
	assign o_read_valid_flag = pv[PIPE_N-1];
	assign o_read_data_oe    = pv[PIPE_N-1];

	// -------------------------------------------------------------
	// echo clocks
	// -------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_echo_clock          <= ECHO_RST;
			o_echo_clock_inverted <= !ECHO_RST;
		end else if (k_rise) begin
			o_echo_clock          <= 1'h1;
			o_echo_clock_inverted <= 1'h0;
		end else if (kn_rise) begin
			o_echo_clock          <= 1'h0;
			o_echo_clock_inverted <= 1'h1;
		end
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	logic [2:0] hcnt;
	logic       rd_dll;

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			hcnt   <= HCNT_MAX;
			rd_dll <= DLL_RST;
		end else if (rd_go) begin
			hcnt   <= 3'h0;
			rd_dll <= dll_on;
		end else if (half_edge && hcnt != HCNT_MAX) begin
			hcnt   <= hcnt + 3'h1;
		end
	end

	read_lat_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		half_edge && hcnt == 3'h4 && rd_dll |=> o_read_valid_flag && !ps[PIPE_N-1])
		else $error("first read beat not out 2.5 cycles after command");

	second_beat_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		half_edge && hcnt == 3'h5 && rd_dll |=> o_read_valid_flag && ps[PIPE_N-1])
		else $error("second read beat not on third primary rise");

	bypass_lat_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		half_edge && hcnt == 3'h1 && !rd_dll |=> o_read_valid_flag && !ps[PIPE_N-1])
		else $error("bypass mode read latency is not one cycle");

	echo_pair_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		o_echo_clock != o_echo_clock_inverted)
		else $error("echo clocks not complementary");

	echo_step_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		k_rise |=> o_echo_clock ##1 o_echo_clock [*3])
		else $error("echo clock did not follow primary rise");

	valid_edge_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		$changed(o_read_valid_flag) |-> $changed(o_echo_clock))
		else $error("read valid moved without an echo edge");

	data_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		!half_edge |=> $stable(o_read_data_out))
		else $error("read data changed between clock edges");

	write_buf_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		wr_go |=> wr_pend && wr_beat0 == $past(d_s[2]))
		else $error("write beat not buffered at write command");

	addr_ignore_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		k_rise && rsel_s[2] |=> $stable(rd_addr))
		else $error("read address taken while deselected");

	wr_addr_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
		$changed(wr_addr) |-> $past(kn_rise) && $past(wr_pend))
		else $error("write address taken off its edge");

endmodule

// file: test/bds_host_model.sv
/*
 bds_host_model: host side of the static memory port, makes the input
 clock pair and drives one command per primary rise from its inputs.
 Assumes: command inputs change no later than 50 ns after an inverted rise.
*/
`timescale 1ns/1ps

module bds_host_model
	import bds_pkg::*;
(
	input  wire logic              i_run,
	input  wire logic              i_rd,
	input  wire logic              i_wr,
	input  wire logic [ADDR_W-1:0] i_rd_addr,
	input  wire logic [ADDR_W-1:0] i_wr_addr,
	input  wire logic [DATA_W-1:0] i_wd0,
	input  wire logic [DATA_W-1:0] i_wd1,
	input  wire logic [NBYTE-1:0]  i_m0,
	input  wire logic [NBYTE-1:0]  i_m1,
	output logic                   o_k,
	output logic                   o_kn,
	output logic      [ADDR_W-1:0] o_addr_in,
	output logic                   o_read_sel_n,
	output logic                   o_write_sel_n,
	output logic      [DATA_W-1:0] o_write_data_in,
	output logic      [NBYTE-1:0]  o_byte_write_mask_n
);
	logic              rd   = 1'b0;
	logic              wr   = 1'b0;
	logic [ADDR_W-1:0] wa;
	logic [DATA_W-1:0] d1;
	logic [NBYTE-1:0]  m1;
	integer            seed = 32'hF396;

	// -------------------------------------------------------------
	// clock pair, low until run
	// -------------------------------------------------------------
	initial begin
		{o_k, o_kn, o_read_sel_n, o_write_sel_n} = 4'h3;
		{o_addr_in, o_write_data_in, o_byte_write_mask_n} = '0;
		wait (i_run === 1'b1);
		#7.3;
		forever begin
			{o_k, o_kn} = 2'h2;
			#100;
			{o_k, o_kn} = 2'h1;
			#100;
		end
	end

	// -------------------------------------------------------------
	// pins, changed mid half period; unused lines carry noise
	// -------------------------------------------------------------
	always @(posedge o_kn) begin
		#50;
		{rd, wr, wa, d1, m1} = {i_rd, i_wr, i_wr_addr, i_wd1, i_m1};
		o_read_sel_n = ~rd;
		o_write_sel_n = ~wr;
		o_addr_in = rd ? i_rd_addr : ADDR_W'($random(seed));
		o_write_data_in = wr ? i_wd0 : DATA_W'($random(seed));
		o_byte_write_mask_n = wr ? i_m0 : NBYTE'($random(seed));
	end
	always @(posedge o_k) begin
		#50;
		o_addr_in = wr ? wa : ADDR_W'($random(seed));
		o_write_data_in = wr ? d1 : DATA_W'($random(seed));
		o_byte_write_mask_n = wr ? m1 : NBYTE'($random(seed));
	end
endmodule

// file: test/bds_port_bench.sv
/*
 bds_port_bench: directed reads and writes in dll mode, random ones in both latency
 modes, beats scored against a word model.
 Assumes: bds_port and bds_host_model, build from bds_pkg.
*/
`timescale 1ns/1ps

module bds_port_bench;
	import bds_pkg::*;
	logic              i_clock = 1'b0;
	logic              i_rst_n = 1'b0;
	logic              dll = 1'b1;
	logic              run = 1'b0;
	logic              k, kn, rs_n, ws_n, oe, vld, cq, cqn, c_rd, c_wr;
	logic              last_cq = 1'b0;
	logic              pend = 1'b0;
	logic [ADDR_W-1:0] addr, c_ra, c_wa;
	logic [DATA_W-1:0] wd, q, c_d0, c_d1;
	logic [NBYTE-1:0]  bw_n, c_m0, c_m1;
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] exp_d [$];
	int                exp_e [$];
	int                fails = 0, checks = 0, ec = 0, last_e0 = 0, lat = 5, cycles = 0;
	integer            seed = 32'hF396;

	initial forever #12.5 i_clock = ~i_clock;

	bds_port bds_port_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_in_clock(k),
		.i_in_clock_inverted(kn), .i_addr_in(addr), .i_read_sel_n(rs_n),
		.i_write_sel_n(ws_n), .i_write_data_in(wd), .i_byte_write_mask_n(bw_n),
		.i_dll_enable(dll), .o_read_data_out(q), .o_read_data_oe(oe),
		.o_read_valid_flag(vld), .o_echo_clock(cq), .o_echo_clock_inverted(cqn));
	bds_host_model bds_host_model_i (.i_run(run), .i_rd(c_rd), .i_wr(c_wr),
		.i_rd_addr(c_ra), .i_wr_addr(c_wa), .i_wd0(c_d0), .i_wd1(c_d1), .i_m0(c_m0),
		.i_m1(c_m1), .o_k(k), .o_kn(kn), .o_addr_in(addr), .o_read_sel_n(rs_n),
		.o_write_sel_n(ws_n), .o_write_data_in(wd), .o_byte_write_mask_n(bw_n));

	// -------------------------------------------------------------
	// compare and close
	// -------------------------------------------------------------
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// -------------------------------------------------------------
	// one command per primary rise, expected beats noted
	// -------------------------------------------------------------
	task automatic op(input logic rd, input logic wr, input int ra, input int wa,
			input logic [NBYTE-1:0] m0, input logic [NBYTE-1:0] m1);
		logic [DATA_W-1:0] d [2];
		int                e0;
		d[0] = DATA_W'($random(seed));
		d[1] = DATA_W'($random(seed));
		{c_rd, c_wr, c_ra, c_wa} = {rd, wr, ADDR_W'(ra), ADDR_W'(wa)};
		{c_d0, c_d1, c_m0, c_m1} = {d[0], d[1], m0, m1};
		@(posedge k);
		@(posedge cq);
		#1;
		e0 = ec + 1;
		if (last_e0 != 0) check("echo run", e0, last_e0 + 2);
		last_e0 = e0;
		for (int b = 0; b < BEATS; b++) begin
			if (rd) begin
				exp_d.push_back(mem[ra * 2 + b]);
				exp_e.push_back(e0 + lat + b);
			end
		end
		for (int b = 0; b < BEATS; b++)
			for (int j = 0; j < NBYTE; j++)
				if (wr && !(b ? m1[j] : m0[j]))
					mem[wa * 2 + b][j * BYTE_W +: BYTE_W] = d[b][j * BYTE_W +: BYTE_W];
	endtask

	// -------------------------------------------------------------
	// output watcher, one cycle after each echo edge
	// -------------------------------------------------------------
	always @(negedge i_clock) if (i_rst_n) begin
		check("echo pair", cqn, !cq);
		check("valid oe", oe, vld);
		if (cq !== last_cq) begin
			ec++;
			pend = 1'b1;
		end else if (pend) begin
			pend = 1'b0;
			if (vld === 1'b1 && exp_d.size() == 0) check("spare beat", 1, 0);
			else if (vld === 1'b1) begin
				check("beat data", q, exp_d.pop_front());
				check("beat slot", ec, exp_e.pop_front());
			end
		end
		last_cq = cq;
	end

	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			test_done();
		end
	end

	initial begin
		{c_rd, c_wr, c_ra, c_wa, c_d0, c_d1, c_m0, c_m1} = '0;
		repeat (10) @(posedge i_clock);
		#1;
		check("reset outputs", {cq, cqn, oe, vld, q}, {4'h4, DATA_W'(0)});
		i_rst_n = 1'b1;
		repeat (5) @(posedge i_clock);
		#1 run = 1'b1;
		op(0, 0, 0, 0, '1, '1);
		for (int a = 0; a < 8; a++) op(0, 1, 0, a, '0, '0);
		op(1, 1, 3, 3, '0, '0);
		op(1, 0, 3, 0, '1, '1);
		for (int m = 0; m < 2; m++) begin
			repeat (30) op(1'($random(seed)), 1'($random(seed)), $random(seed) & 7,
				$random(seed) & 7, NBYTE'($random(seed)), NBYTE'($random(seed)));
			repeat (4) op(0, 0, 0, 0, '1, '1);
			@(posedge i_clock);
			#1;
			dll = 1'b0;
			lat = 2;
		end
		check("beats left", exp_d.size(), 0);
		test_done();
	end
endmodule
